//--- src/gdfc_top.sv
// How it works
// - Low-side source code bits 7:4, reset 1111
// - Low-side sink code bits 3:0, reset 1111
// - Gate-fault mode: latch, cycle, warn, off
// - Drive/blank time 96, 2, 4, 8 us
// - Dead-time codes 0 to 8000 ns
// - Gate fault local shutdown in modes 00/11
// - Overcurrent mode: latch, cycle, warn, off
// - Overcurrent deglitch 1, 2, 4, 8 us
// - Post-fault pulldown: programmed or fixed current
// - Gate monitor threshold 1.4 V or 1.0 V
// - Overcurrent local shutdown in modes 00/11
// - Bridge mode: independent, ph/en, pwm, split
// - Overcurrent thresholds 4-bit, reset 1101
`timescale 1ns/1ps
`default_nettype none
`include "gdfc_defs.svh"
module gdfc_top
   import gdfc_pkg::*;
(
   input  wire logic       core_clk,          // 50 MHz
   input  wire logic       nrst,              // Sync reset, active low
   input  wire logic       spi_cs_n,          // Frame select, active low
   input  wire logic       spi_sclk,          // Serial clock, sampled
   input  wire logic       spi_mosi,          // Serial data in
   output logic            spi_miso,          // Serial data out
   input  wire logic [1:0] bridge_input_mode, // From bridge control register
   input  wire logic       gate_fault_in,     // Raw gate fault event
   input  wire logic       gate_fault_hb,     // Half-bridge of the gate fault
   input  wire logic       oc_fault_in,       // Raw overcurrent comparator
   input  wire logic       oc_fault_hb,       // Half-bridge of the overcurrent
   output logic [3:0]      ls_source_current_code,
   output logic [3:0]      ls_sink_current_code,
   output logic [1:0]      gate_fault_mode,
   output logic [1:0]      drive_and_blank_time,
   output logic [2:0]      inserted_dead_time,
   output logic [1:0]      overcurrent_mode,
   output logic [1:0]      overcurrent_deglitch,
   output logic [3:0]      pulldown_current_code, // Resolved post-fault sink code
   output logic            gate_monitor_threshold,
   output logic [3:0]      high_side_oc_threshold,
   output logic [3:0]      low_side_oc_threshold,
   output logic [15:0]     drive_time_cycles,
   output logic [15:0]     dead_time_cycles,
   output logic [15:0]     deglitch_cycles,
   output logic [1:0]      hb_shutdown,       // Per half-bridge off request
   output logic            fault_warn         // Warning-only report
);
   // Serial frame: bit15 read, bits14:9 address, bits7:0 data
   gdfc_state_t st_reg;                       // Frame state
   gdfc_state_t st_next;
   logic [15:0] sh_reg;                       // Input shift register
   logic [4:0]  cnt_reg;                      // Bit counter
   logic        sclk_d_reg;                   // Delayed clock sample
   logic [7:0]  out_reg;                      // Output shift register
   logic        rd_hit_reg;                   // Frame is a read of a held register
   wire         sclk_rise = spi_sclk & ~sclk_d_reg;
   wire         sclk_fall = ~spi_sclk & sclk_d_reg;
   wire [15:0]  frame     = {sh_reg[14:0], spi_mosi};
   wire [5:0]   addr      = sh_reg[14:9];
   wire         is_read   = sh_reg[15];
   // Address decode
   wire         hit = (addr >= `GDFC_ADDR_LS_CUR) && (addr <= `GDFC_ADDR_OC_THR);
   wire [1:0]   idx = 2'(addr - `GDFC_ADDR_LS_CUR);
   wire         wr_en = (st_reg == GDFC_ST_DONE) && !is_read && hit;
   // Before the eighth rising clock the header sits in the low seven bits
   wire [5:0]   early_addr = sh_reg[5:0];
   wire         rd_hit = sh_reg[6] && (early_addr >= `GDFC_ADDR_LS_CUR) &&
                         (early_addr <= `GDFC_ADDR_OC_THR);
   logic [7:0]  rd_data;
   logic [31:0] regs;
   // Store
   gdfc_regfile u_rf (
      .core_clk (core_clk),
      .nrst     (nrst),
      .wr_en    (wr_en),
      .wr_idx   (idx),
      .wr_data  (sh_reg[7:0]),
      .rd_idx   (2'(early_addr - `GDFC_ADDR_LS_CUR)),
      .rd_data  (rd_data),
      .all_regs (regs)
   );
   // Frame state machine
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         GDFC_ST_IDLE:  if (!spi_cs_n) st_next = GDFC_ST_SHIFT;
         GDFC_ST_SHIFT: begin
            if (spi_cs_n) st_next = (cnt_reg == 5'd16) ? GDFC_ST_DONE : GDFC_ST_IDLE;
         end
         GDFC_ST_DONE:  st_next = GDFC_ST_IDLE;
         default:       st_next = GDFC_ST_IDLE;
      endcase
   end
   // Shifter and counters
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_reg <= GDFC_ST_IDLE;
         sh_reg <= 16'h0000;
         cnt_reg <= 5'd0;
         sclk_d_reg <= 1'b0;
         out_reg <= 8'h00;
         rd_hit_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         sclk_d_reg <= spi_sclk;
         if (st_reg == GDFC_ST_IDLE) begin
            cnt_reg <= 5'd0;
            rd_hit_reg <= 1'b0;
         end else if (st_reg == GDFC_ST_SHIFT && !spi_cs_n && sclk_rise) begin
            sh_reg <= frame;
            cnt_reg <= (cnt_reg == 5'd16) ? cnt_reg : cnt_reg + 5'd1;
         end
         // Load read data once the address byte is in
         if (st_reg == GDFC_ST_SHIFT && sclk_rise && cnt_reg == 5'd7) begin
            out_reg <= rd_data;
            rd_hit_reg <= rd_hit;
         end else if (sclk_fall && cnt_reg > 5'd8) begin
            out_reg <= {out_reg[6:0], 1'b0};
         end
      end
   end
   // Data out: read data in the second byte, zero otherwise
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         spi_miso <= 1'b0;
      end else begin
         spi_miso <= (cnt_reg >= 5'd8 && rd_hit_reg) ? out_reg[7] : 1'b0;
      end
   end
   // Field unpack
   wire [7:0] r_cur = regs[7:0];
   wire [7:0] r_tim = regs[15:8];
   wire [7:0] r_oc  = regs[23:16];
   wire [7:0] r_thr = regs[31:24];
   assign ls_source_current_code = r_cur[`GDFC_SRC_LSB +: 4];
   assign ls_sink_current_code   = r_cur[`GDFC_SNK_LSB +: 4];
   assign gate_fault_mode        = r_tim[`GDFC_MODE_LSB +: 2];
   assign drive_and_blank_time   = r_tim[`GDFC_TIME_LSB +: 2];
   assign inserted_dead_time     = r_tim[`GDFC_DEAD_LSB +: 3];
   wire   gate_fault_local_shutdown = r_tim[`GDFC_IND_BIT];
   assign overcurrent_mode       = r_oc[`GDFC_MODE_LSB +: 2];
   assign overcurrent_deglitch   = r_oc[`GDFC_TIME_LSB +: 2];
   wire [1:0] post_fault_pulldown = r_oc[`GDFC_PDN_LSB +: 2];
   assign gate_monitor_threshold = r_oc[`GDFC_LVL_BIT];
   wire   overcurrent_local_shutdown = r_oc[`GDFC_IND_BIT];
   assign high_side_oc_threshold = r_thr[7:4];
   assign low_side_oc_threshold  = r_thr[3:0];
   // Pulldown: programmed sink, else 8, 31, 62 mA codes
   assign pulldown_current_code = (post_fault_pulldown == 2'h0) ? ls_sink_current_code :
                                  (post_fault_pulldown == 2'h1) ? 4'h6 :
                                  (post_fault_pulldown == 2'h2) ? 4'hC : 4'hF;
   // Time codes to cycle counts
   assign drive_time_cycles = (drive_and_blank_time == 2'h0) ? 16'(96 * `GDFC_CLK_MHZ) :
                              16'(`GDFC_CYC_PER_US << drive_and_blank_time);
   assign deglitch_cycles = 16'(`GDFC_CYC_PER_US << overcurrent_deglitch);
   assign dead_time_cycles = (inserted_dead_time < 3'h4) ?
                             16'(`GDFC_CYC_PER_QUS * inserted_dead_time) :
                             16'(`GDFC_CYC_PER_US << (inserted_dead_time - 3'h4));
   // Local shutdown only in independent or split bridge modes
   wire local_ok = (bridge_input_mode == GDFC_BRG_INDEP) ||
                   (bridge_input_mode == GDFC_BRG_SPLIT);
   wire gf_act = gate_fault_in && (gate_fault_mode == GDFC_MON_LATCH ||
                                   gate_fault_mode == GDFC_MON_CYCLE);
   wire oc_act = oc_fault_in && (overcurrent_mode == GDFC_MON_LATCH ||
                                 overcurrent_mode == GDFC_MON_CYCLE);
   wire [1:0] gf_mask = (gate_fault_local_shutdown && local_ok) ?
                        (gate_fault_hb ? 2'b10 : 2'b01) : 2'b11;
   wire [1:0] oc_mask = (overcurrent_local_shutdown && local_ok) ?
                        (oc_fault_hb ? 2'b10 : 2'b01) : 2'b11;
   wire [1:0] gf_sd = gf_act ? gf_mask : 2'b00;
   wire [1:0] oc_sd = oc_act ? oc_mask : 2'b00;
   // Latched faults hold until reset; cycle-by-cycle follow the input
   logic [1:0] latch_reg;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         latch_reg <= 2'b00;
      end else begin
         latch_reg <= latch_reg | ((gate_fault_mode == GDFC_MON_LATCH) ? gf_sd : 2'b00)
                                | ((overcurrent_mode == GDFC_MON_LATCH) ? oc_sd : 2'b00);
      end
   end
   assign hb_shutdown = latch_reg | gf_sd | oc_sd;
   assign fault_warn = (gate_fault_in && gate_fault_mode == GDFC_MON_WARN) ||
                       (oc_fault_in && overcurrent_mode == GDFC_MON_WARN);
endmodule
`default_nettype wire

//--- common/gdfc_defs.svh
`ifndef GDFC_DEFS_SVH
`define GDFC_DEFS_SVH
// Register addresses
`define GDFC_ADDR_LS_CUR      6'h07
`define GDFC_ADDR_GATE_TIM    6'h08
`define GDFC_ADDR_OC_CTRL     6'h09
`define GDFC_ADDR_OC_THR      6'h0A
// Reset values
`define GDFC_RST_LS_CUR       8'hFF
`define GDFC_RST_GATE_TIM     8'h20
`define GDFC_RST_OC_CTRL      8'h20
`define GDFC_RST_OC_THR       8'hDD
// Field positions (low bit)
`define GDFC_SRC_LSB          4
`define GDFC_SNK_LSB          0
`define GDFC_MODE_LSB         6
`define GDFC_TIME_LSB         4
`define GDFC_DEAD_LSB         1
`define GDFC_IND_BIT          0
`define GDFC_PDN_LSB          2
`define GDFC_LVL_BIT          1
// Time units at 50 MHz: cycles per microsecond and per 250 ns
`define GDFC_CLK_MHZ          50
`define GDFC_CYC_PER_US       16'd50
`define GDFC_CYC_PER_QUS      16'd13
`endif

//--- common/gdfc_pkg.sv
package gdfc_pkg;
   // Monitor response modes
   typedef enum logic [1:0] {
      GDFC_MON_LATCH = 2'h0,
      GDFC_MON_CYCLE = 2'h1,
      GDFC_MON_WARN  = 2'h2,
      GDFC_MON_OFF   = 2'h3
   } gdfc_mon_mode_t;
   // Bridge input control modes
   typedef enum logic [1:0] {
      GDFC_BRG_INDEP = 2'h0,
      GDFC_BRG_PHEN  = 2'h1,
      GDFC_BRG_PWM   = 2'h2,
      GDFC_BRG_SPLIT = 2'h3
   } gdfc_bridge_input_mode_t;
   // Serial port frame states, one-hot
   typedef enum logic [2:0] {
      GDFC_ST_IDLE = 3'b001,
      GDFC_ST_SHIFT = 3'b010,
      GDFC_ST_DONE = 3'b100
   } gdfc_state_t;
endpackage

//--- src/gdfc_regfile.sv
`timescale 1ns/1ps
`default_nettype none
`include "gdfc_defs.svh"
// Four-entry register store, read data registered
module gdfc_regfile
   import gdfc_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       wr_en,
   input  wire logic [1:0] wr_idx,
   input  wire logic [7:0] wr_data,
   input  wire logic [1:0] rd_idx,
   output logic      [7:0] rd_data,
   output logic      [31:0] all_regs
);
   logic [7:0] mem_reg [4];          // Storage
   // Reset values per entry
   localparam logic [7:0] RST [4] = '{`GDFC_RST_LS_CUR, `GDFC_RST_GATE_TIM,
                                      `GDFC_RST_OC_CTRL, `GDFC_RST_OC_THR};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ent
         // One entry: reset to default, write on select
         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               mem_reg[gi] <= RST[gi];
            end else if (wr_en && wr_idx == 2'(gi)) begin
               mem_reg[gi] <= wr_data;
            end
         end
         assign all_regs[gi*8 +: 8] = mem_reg[gi];
      end
   endgenerate
   // Registered read port
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= mem_reg[rd_idx];
      end
   end
endmodule
`default_nettype wire

//--- test/gdfc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Checks field decoding and register stability at the top ports
module gdfc_chk (
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        spi_cs_n,
   input wire logic        spi_miso,
   input wire logic [3:0]  ls_source_current_code,
   input wire logic [3:0]  ls_sink_current_code,
   input wire logic [1:0]  gate_fault_mode,
   input wire logic [1:0]  drive_and_blank_time,
   input wire logic [2:0]  inserted_dead_time,
   input wire logic [1:0]  overcurrent_mode,
   input wire logic [1:0]  overcurrent_deglitch,
   input wire logic        gate_monitor_threshold,
   input wire logic [3:0]  high_side_oc_threshold,
   input wire logic [3:0]  low_side_oc_threshold,
   input wire logic [15:0] drive_time_cycles,
   input wire logic [15:0] dead_time_cycles,
   input wire logic [15:0] deglitch_cycles,
   input wire logic        fault_warn
);
   // All visible fields in one word
   wire logic [27:0] flds = {ls_source_current_code, ls_sink_current_code, gate_fault_mode,
      drive_and_blank_time, inserted_dead_time, overcurrent_mode, overcurrent_deglitch,
      gate_monitor_threshold, high_side_oc_threshold, low_side_oc_threshold};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Select idle long enough for any pending write to have landed
   sequence s_quiet; spi_cs_n [*5]; endsequence
   property p_rst; $rose(nrst) |-> flds == {8'hFF, 4'h2, 3'h0, 4'h2, 1'h0, 8'hDD}; endproperty
   property p_hold; s_quiet |-> $stable(flds); endproperty
   property p_drv; drive_time_cycles == (drive_and_blank_time == 2'h0 ? 16'd4800
      : 16'd50 << drive_and_blank_time); endproperty
   property p_dg; deglitch_cycles == 16'd50 << overcurrent_deglitch; endproperty
   property p_dlong; inserted_dead_time[2] |->
      dead_time_cycles == 16'd50 << inserted_dead_time[1:0]; endproperty
   property p_dshort; inserted_dead_time < 3'h2 |->
      dead_time_cycles == (inserted_dead_time == 3'h1 ? 16'd13 : 16'd0); endproperty
   property p_miso; spi_cs_n && $past(spi_cs_n) |-> !spi_miso; endproperty
   property p_warn; fault_warn |-> gate_fault_mode == 2'h2 || overcurrent_mode == 2'h2
      || $past(gate_fault_mode) == 2'h2 || $past(overcurrent_mode) == 2'h2; endproperty
   a_rst: assert property (p_rst) else $error("fields differ from reset values");
   a_hold: assert property (p_hold) else $error("field changed without a frame");
   a_drv: assert property (p_drv) else $error("drive time count wrong");
   a_dg: assert property (p_dg) else $error("deglitch count wrong");
   a_dlong: assert property (p_dlong) else $error("long dead time count wrong");
   a_dshort: assert property (p_dshort) else $error("short dead time count wrong");
   a_miso: assert property (p_miso) else $error("read data driven while idle");
   a_warn: assert property (p_warn) else $error("warning outside warning mode");
endmodule
bind gdfc_top gdfc_chk u_chk (.*);
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
   $display("Error %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
   import gdfc_pkg::*;
   logic        core_clk = 0, nrst = 0, cs_n = 1, sclk = 0, mosi = 0;
   logic [1:0]  brg = 0, b, m, eh, hb;
   logic        gf = 0, gh = 0, of = 0, oh = 0, o, h, d, ew, miso, warn;
   logic [3:0]  src, snk, pdn, hs, ls;
   logic [1:0]  gm, tdrv, ocm, dg;
   logic [2:0]  dead;
   logic        lvl;
   logic [15:0] drvc, dedc, dgc;
   logic [7:0]  sh [4], rd, e, q [$];
   logic [9:0]  ft [9] = '{10'h05C, 10'h15E, 10'h316, 10'h39A, 10'h29E,
      10'h021, 10'h0A1, 10'h0F0, 10'h006};
   int          mismatches = 0, comparisons = 0, cyc = 0;
   event        got;
   gdfc_top uut (.core_clk(core_clk), .nrst(nrst), .spi_cs_n(cs_n), .spi_sclk(sclk),
      .spi_mosi(mosi), .spi_miso(miso), .bridge_input_mode(brg), .gate_fault_in(gf),
      .gate_fault_hb(gh), .oc_fault_in(of), .oc_fault_hb(oh), .ls_source_current_code(src),
      .ls_sink_current_code(snk), .gate_fault_mode(gm), .drive_and_blank_time(tdrv),
      .inserted_dead_time(dead), .overcurrent_mode(ocm), .overcurrent_deglitch(dg),
      .pulldown_current_code(pdn), .gate_monitor_threshold(lvl), .high_side_oc_threshold(hs),
      .low_side_oc_threshold(ls), .drive_time_cycles(drvc), .dead_time_cycles(dedc),
      .deglitch_cycles(dgc), .hb_shutdown(hb), .fault_warn(warn));
   initial forever #10 core_clk = ~core_clk;
   // Hang guard
   always @(posedge core_clk) if (++cyc == 60000) begin mismatches++; conclude(); end
   // Read results against the oldest note
   always @(got) begin e = q.pop_front(); `CHK(rd, e) end
   task conclude;
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One frame, MSB first, n bits, sclk phases of 4 cycles
   task automatic frame(input logic [15:0] w, input int n);
      cs_n = 0;
      for (int k = 0; k < n; k++) begin
         mosi = w[15-k];
         sclk = 0;
         repeat (4) @(negedge core_clk);
         if (k > 7) rd = {rd[6:0], miso};
         sclk = 1;
         repeat (4) @(negedge core_clk);
      end
      sclk = 0;
      repeat (4) @(negedge core_clk);
      cs_n = 1;
      mosi = ~mosi;
      repeat (5) @(negedge core_clk);
   endtask
   task automatic wr(input int a, input logic [7:0] v);
      frame({1'b0, 6'(a), 1'b0, v}, 16);
      if (a >= 7 && a <= 10) sh[a-7] = v;
   endtask
   task automatic rdc(input int a);
      frame({1'b1, 6'(a), 9'h0}, 16);
      q.push_back((a >= 7 && a <= 10) ? sh[a-7] : 8'h00);
      -> got;
   endtask
   task fields;
      `CHK({src, snk}, sh[0])
      `CHK({gm, tdrv, dead}, sh[1][7:1])
      `CHK({ocm, dg, lvl}, {sh[2][7:4], sh[2][1]})
      `CHK({hs, ls}, sh[3])
      `CHK(drvc, sh[1][5:4] == 2'h0 ? 16'd4800 : 16'd50 << sh[1][5:4])
      `CHK(dgc, 16'd50 << sh[2][5:4])
      `CHK(pdn, sh[2][3:2] == 2'h0 ? sh[0][3:0] : sh[2][3:2] == 2'h1 ? 4'h6
         : sh[2][3:2] == 2'h2 ? 4'hC : 4'hF)
   endtask
   task allrd;
      for (int a = 6; a < 12; a++) rdc(a);
      fields();
   endtask
   task rst;
      nrst = 0;
      repeat (6) @(negedge core_clk);
      nrst = 1;
      sh = '{8'hFF, 8'h20, 8'h20, 8'hDD};
      allrd();
   endtask
   initial begin
      void'($urandom(71320));
      rst();
      repeat (3) for (int a = 7; a < 11; a++) begin
         wr(a, 8'($urandom));
         rdc(a);
         fields();
      end
      for (int c = 0; c < 8; c++) begin
         wr(8, {2'h1, c[1:0], c[2:0], 1'b1});
         wr(9, {2'h3, c[1:0], c[1:0], 2'h1});
         fields();
         if (c != 2 && c != 3)
            `CHK(dedc, c == 0 ? 16'd0 : c == 1 ? 16'd13 : 16'd50 << (c - 4))
      end
      wr(11, 8'h00);
      frame({1'b0, 6'h08, 1'b0, 8'h00}, 15);
      allrd();
      // Fault cases: mode, bridge mode, half-bridge and local shutdown
      foreach (ft[i]) begin
         {b, o, h, m, d, eh, ew} = ft[i];
         brg = b;
         wr(8, {o ? 2'h3 : m, 2'h1, 3'h0, d});
         wr(9, {o ? m : 2'h3, 4'h0, 1'b0, d});
         {gh, oh, gf, of} = {h, h, !o, o};
         repeat (500) @(negedge core_clk);
         `CHK({hb, warn}, {eh, ew})
         {gf, of} = 2'h0;
         repeat (500) @(negedge core_clk);
         `CHK({hb, warn}, {m == 2'h0 ? 2'h3 : 2'h0, 1'b0})
      end
      rst();
      `CHK(hb, 2'h0)
      repeat (3) @(negedge core_clk);
      conclude();
   end
endmodule
`default_nettype wire
